// [design/lsc_defines.svh]
// Register layout and timing constants of the light sensor conversion control.
// Operation
// - Range select in bits 15:12 picks full scale, coded like the exponent.
// - Range select 1100b picks the range itself and reports it as exponent.
// - After reset range select holds 1100b, so automatic range is on.
// - Short time loses 1 bit at 0101b, 2 at 0100b to 0001b, 3 at 0000b.
// - Result format and bit weight do not depend on the conversion time.
// - Mode 00 is off, 01 single-shot, 1x continuous, and resets to 00b.
// - Single-shot reads 01b while converting and drops to 00b when done.
// - Entering shutdown leaves ready flag and limit flags as is.
// - Read-only overflow bit 8 follows the overflow of each conversion.
// - In a manual range a transient overload may set the overflow flag.
// - Auto range overflow below the top range steps up and restarts.
// - Ready bit 7 sets at conversion end, clears on read or non-off write.
// - Any write at offset 01h aborts a conversion, and a converting mode starts anew.
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH
// ************************************************************
// Register layout
// ************************************************************
`define LSC_CFG_OFFSET 8'h01
`define LSC_CFG_RESET 16'hc810
`define LSC_RANGE_MSB 15
`define LSC_RANGE_LSB 12
`define LSC_CTIME_BIT 11
`define LSC_MODE_MSB 10
`define LSC_MODE_LSB 9
`define LSC_OVF_BIT 8
`define LSC_DONE_BIT 7
`define LSC_WMASK 16'hfe1f
`define LSC_RANGE_AUTO 4'hc
`define LSC_RANGE_MAX 4'hb
// ************************************************************
// Timing
// ************************************************************
`define LSC_CLK_HZ 40000000
`define LSC_SHORT_MS 100
`define LSC_LONG_MS 800
`define LSC_SHORT_CYC (`LSC_CLK_HZ / 1000 * `LSC_SHORT_MS)
`define LSC_LONG_CYC (`LSC_CLK_HZ / 1000 * `LSC_LONG_MS)
`endif

// [design/lsc_pkg.sv]
// Types of the light sensor conversion control.
package lsc_pkg;
    typedef enum logic [1:0] {
        LSC_MODE_OFF = 2'h0,
        LSC_MODE_SINGLE = 2'h1,
        LSC_MODE_CONT_A = 2'h2,
        LSC_MODE_CONT_B = 2'h3
    } lsc_mode_t;
    typedef struct packed {
        logic [3:0] range_select;
        logic conversion_time_sel;
        logic [1:0] mode;
        logic overflow_flag;
        logic conversion_done_flag;
        logic high_limit_flag;
        logic low_limit_flag;
        logic [4:0] low_bits;
    } lsc_cfg_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } lsc_reg_req_t;
    typedef struct packed {
        logic done;
        logic overflow;
        logic [3:0] range_used;
    } lsc_conv_res_t;
endpackage

// [design/lsc_timer.sv]
// Integration timer that counts one conversion and reports its end.
`timescale 1ns/1ps
`include "lsc_defines.svh"
module lsc_timer
    import lsc_pkg::*;
#(
    parameter int SHORT_CYC = `LSC_SHORT_CYC,
    parameter int LONG_CYC = `LSC_LONG_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic long_i,
    output logic busy_o,
    output logic end_o
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic busy_next;
    wire [31:0] length = long_i ? LONG_CYC[31:0] : SHORT_CYC[31:0];
    if (SHORT_CYC < 2 || LONG_CYC < SHORT_CYC) begin : g_bad_len
        $error("lsc_timer: bad conversion lengths");
    end
    always_comb begin
        count_next = count_reg;
        busy_next = busy_o;
        if (abort_i || start_i) begin
            count_next = length - 32'h1;
            busy_next = start_i;
        end else if (busy_o && count_reg == 32'h0) begin
            busy_next = 1'b0;
        end else if (busy_o) begin
            count_next = count_reg - 32'h1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            count_reg <= 32'h0;
            busy_o <= 1'b0;
            end_o <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_o <= busy_next;
            end_o <= busy_o && count_reg == 32'h0 && !abort_i && !start_i;
        end
    end
endmodule // lsc_timer

// [design/lsc_conv_ctrl.sv]
// Configuration register and conversion sequencing of the light sensor.
`timescale 1ns/1ps
`include "lsc_defines.svh"
module lsc_conv_ctrl
    import lsc_pkg::*;
#(
    parameter int SHORT_CYC = `LSC_SHORT_CYC,
    parameter int LONG_CYC = `LSC_LONG_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic adc_overflow_i,
    input wire logic high_limit_flag_i,
    input wire logic low_limit_flag_i,
    output logic [15:0] reg_rdata_o,
    output logic converting_o,
    output logic [3:0] result_exponent_o,
    output logic [1:0] resolution_loss_o,
    output logic result_valid_o
);
    // ************************************************************
    // Register access decode
    // ************************************************************
    lsc_cfg_t cfg_reg;
    lsc_cfg_t cfg_next;
    logic [3:0] auto_range_reg;
    logic [3:0] auto_range_next;
    lsc_conv_res_t res;
    wire cfg_hit = reg_addr_i == `LSC_CFG_OFFSET;
    wire cfg_wr = reg_wr_i && cfg_hit;
    wire cfg_rd = reg_rd_i && cfg_hit && !reg_wr_i;
    wire [15:0] wr_val = (reg_wdata_i & `LSC_WMASK) |
                         (16'(cfg_reg) & ~`LSC_WMASK);
    wire [1:0] new_mode = reg_wdata_i[`LSC_MODE_MSB:`LSC_MODE_LSB];
    wire new_converts = new_mode != LSC_MODE_OFF;
    wire is_auto = cfg_reg.range_select == `LSC_RANGE_AUTO;
    wire [3:0] range_now = is_auto ? auto_range_reg : cfg_reg.range_select;
    wire timer_busy;
    wire timer_end;
    wire step_up = timer_end && adc_overflow_i && is_auto &&
                   auto_range_reg != `LSC_RANGE_MAX;
    wire conv_end = timer_end && !step_up;
    wire start = (cfg_wr && new_converts) || step_up ||
                 (conv_end && cfg_reg.mode[1]);
    function automatic logic [1:0] loss_of(input logic [3:0] rng,
                                           input logic long_sel);
        logic [1:0] l;
        l = 2'h0;
        if (!long_sel) begin
            if (rng == 4'h5) l = 2'h1;
            else if (rng >= 4'h1 && rng <= 4'h4) l = 2'h2;
            else if (rng == 4'h0) l = 2'h3;
        end
        return l;
    endfunction
    // ************************************************************
    // Next register value
    // ************************************************************
    always_comb begin
        cfg_next = cfg_reg;
        auto_range_next = auto_range_reg;
        if (cfg_rd) cfg_next.conversion_done_flag = 1'b0;
        if (cfg_wr) begin
            cfg_next = lsc_cfg_t'(wr_val);
            if (new_converts) cfg_next.conversion_done_flag = 1'b0;
            if (reg_wdata_i[`LSC_RANGE_MSB:`LSC_RANGE_LSB] == `LSC_RANGE_AUTO)
                auto_range_next = 4'h0;
        end else if (step_up) begin
            auto_range_next = auto_range_reg + 4'h1;
        end else if (conv_end) begin
            // Flags survive the drop to shutdown for later reads.
            cfg_next.conversion_done_flag = 1'b1;
            cfg_next.overflow_flag = adc_overflow_i;
            if (cfg_reg.mode == LSC_MODE_SINGLE)
                cfg_next.mode = LSC_MODE_OFF;
        end
        cfg_next.high_limit_flag = high_limit_flag_i;
        cfg_next.low_limit_flag = low_limit_flag_i;
    end
    assign res = '{done: conv_end, overflow: adc_overflow_i,
                   range_used: range_now};
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cfg_reg <= lsc_cfg_t'(`LSC_CFG_RESET);
            auto_range_reg <= 4'h0;
        end else begin
            cfg_reg <= cfg_next;
            auto_range_reg <= auto_range_next;
        end
    end
    // Outputs register the state so the pins never see decode glitches.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rdata_o <= `LSC_CFG_RESET;
            converting_o <= 1'b0;
            result_exponent_o <= 4'h0;
            resolution_loss_o <= 2'h0;
            result_valid_o <= 1'b0;
        end else begin
            reg_rdata_o <= 16'(cfg_next);
            converting_o <= timer_busy;
            if (res.done) begin
                result_exponent_o <= res.range_used;
                resolution_loss_o <= loss_of(res.range_used,
                    cfg_reg.conversion_time_sel);
            end
            result_valid_o <= res.done;
        end
    end
    lsc_timer #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .start_i(start),
        .abort_i(cfg_wr),
        .long_i(cfg_wr ? reg_wdata_i[`LSC_CTIME_BIT]
                       : cfg_reg.conversion_time_sel),
        .busy_o(timer_busy),
        .end_o(timer_end)
    );
    // ************************************************************
    // Checks
    // ************************************************************
    a_single_returns_off: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) conv_end && !cfg_wr &&
        cfg_reg.mode == LSC_MODE_SINGLE |=> cfg_reg.mode == LSC_MODE_OFF)
        else $error("single-shot did not return to shutdown");
    a_done_sets: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) conv_end && !cfg_wr |=>
        cfg_reg.conversion_done_flag)
        else $error("ready flag not set at conversion end");
    a_read_clears: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) cfg_rd && !conv_end |=>
        !cfg_reg.conversion_done_flag)
        else $error("read did not clear ready flag");
    a_off_write_keeps: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) cfg_wr && !new_converts && !cfg_rd |=>
        $stable(cfg_reg.conversion_done_flag))
        else $error("shutdown write changed ready flag");
    a_ovf_tracks: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) conv_end && !cfg_wr |=>
        cfg_reg.overflow_flag == $past(adc_overflow_i))
        else $error("overflow flag wrong");
    a_auto_steps_up: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) step_up && !cfg_wr |=>
        auto_range_reg == $past(auto_range_reg) + 4'h1 ##1 timer_busy)
        else $error("auto range did not step and restart");
    a_write_aborts: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) cfg_wr && !new_converts |=> !timer_busy)
        else $error("write did not abort conversion");
    a_write_restarts: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) cfg_wr && new_converts |=> timer_busy
        ##1 converting_o)
        else $error("converting write did not start");
    a_exp_reported: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) conv_end |=>
        result_exponent_o == $past(range_now) && result_valid_o)
        else $error("exponent not reported");
endmodule // lsc_conv_ctrl

// [test/lsc_light_model.sv]
// Light and converter model feeding overload and limit levels to the block.
`timescale 1ns/1ps
module lsc_light_model (
    input wire logic clk_sys_i,
    input wire logic overload_i,
    input wire logic high_i,
    input wire logic low_i,
    output logic adc_overflow_o,
    output logic high_limit_flag_o,
    output logic low_limit_flag_o
);
    // Levels move just after an edge, like a real converter's output stage.
    always @(posedge clk_sys_i) begin
        adc_overflow_o <= #2 overload_i;
        high_limit_flag_o <= #2 high_i;
        low_limit_flag_o <= #2 low_i;
    end
endmodule // lsc_light_model

// [test/tb_top.sv]
// Self-checking bench of the light sensor conversion control.
`timescale 1ns/1ps
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end end
module tb_top;
    import lsc_pkg::*;
    logic clk_sys_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000, rdata_o, d;
    logic overload = 0, high = 0, low = 0, last_ov = 0;
    logic adc_ovf, hi_f, lo_f;
    logic conv_o, valid_o;
    logic [3:0] exp_o;
    logic [1:0] loss_o;
    int num_errors = 0, checked = 0, cycles = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    lsc_light_model u_lsc_light_model (.clk_sys_i(clk_sys_i),
        .overload_i(overload), .high_i(high), .low_i(low),
        .adc_overflow_o(adc_ovf), .high_limit_flag_o(hi_f),
        .low_limit_flag_o(lo_f));
    // Short counts keep the run brief; the fixed waits below are sized for them.
    lsc_conv_ctrl #(.SHORT_CYC(20), .LONG_CYC(40)) u_lsc_conv_ctrl (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .adc_overflow_i(adc_ovf),
        .high_limit_flag_i(hi_f), .low_limit_flag_i(lo_f),
        .reg_rdata_o(rdata_o), .converting_o(conv_o),
        .result_exponent_o(exp_o), .resolution_loss_o(loss_o),
        .result_valid_o(valid_o));
    task automatic complete_run();
        $display("errors %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge clk_sys_i);
        #2;
        reg_wr_i = 1;
        reg_addr_i = a;
        reg_wdata_i = w;
        @(posedge clk_sys_i);
        #2;
        reg_wr_i = 0;
    endtask
    // Read data is the value standing while the request is held.
    task automatic rd(output logic [15:0] v);
        @(posedge clk_sys_i);
        #2;
        reg_rd_i = 1;
        reg_addr_i = 8'h01;
        v = rdata_o;
        @(posedge clk_sys_i);
        #2;
        reg_rd_i = 0;
    endtask
    task automatic wait_valid(input int limit);
        int n;
        n = 0;
        while (valid_o !== 1'b1 && n < limit) begin
            @(posedge clk_sys_i);
            #2;
            n++;
        end
        `CHECK(valid_o, 1'b1)
    endtask
    function automatic logic [1:0] loss_of(input logic [3:0] r, logic ct);
        if (ct || r > 4'h5) return 2'h0;
        return (r == 4'h5) ? 2'h1 : (r == 4'h0) ? 2'h3 : 2'h2;
    endfunction
    // One single-shot run; the host polls for completion before reading.
    task automatic shot(input logic [15:0] w, logic [3:0] er, logic ov);
        wr(8'h01, w);
        `CHECK(rdata_o, w | {7'h00, last_ov, 8'h00})
        // Twelve auto-range conversions of 21 cycles each fit in this limit.
        wait_valid(300);
        `CHECK(exp_o, er)
        `CHECK(loss_o, loss_of(er, w[11]))
        `CHECK(rdata_o, {w[15:11], 2'b00, ov, 1'b1, 7'h00})
        @(posedge clk_sys_i);
        #2;
        `CHECK(valid_o, 1'b0)
        last_ov = ov;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #2;
        reset_i = 0;
        `CHECK(rdata_o, 16'hc810)
        wr(8'h02, 16'h5400);
        `CHECK(rdata_o, 16'hc810)
        // Reserved range codes above 4'hb are never written.
        for (int r = 0; r < 12; r++) begin
            shot({r[3:0], 1'b0, 2'b01, 9'h000}, r[3:0], 1'b0);
        end
        shot(16'h3a00, 4'h3, 1'b0);
        high = 1;
        low = 1;
        wr(8'h01, 16'h3000);
        repeat (2) @(posedge clk_sys_i);
        #2;
        `CHECK(rdata_o, 16'h30e0)
        rd(d);
        `CHECK(d, 16'h30e0)
        high = 0;
        low = 0;
        repeat (3) @(posedge clk_sys_i);
        #2;
        `CHECK(rdata_o, 16'h3000)
        overload = 1;
        shot(16'h3200, 4'h3, 1'b1);
        shot(16'hc200, 4'hb, 1'b1);
        overload = 0;
        shot(16'h3200, 4'h3, 1'b0);
        shot(16'hc200, 4'h0, 1'b0);
        wr(8'h01, 16'h5400);
        repeat (10) @(posedge clk_sys_i);
        wr(8'h01, 16'h5600);
        repeat (15) begin
            @(posedge clk_sys_i);
            #2;
            `CHECK(valid_o, 1'b0)
            `CHECK(conv_o, 1'b1)
        end
        wait_valid(40);
        @(posedge clk_sys_i);
        #2;
        wait_valid(40);
        `CHECK(rdata_o[10:9], 2'b11)
        wr(8'h01, 16'h5000);
        `CHECK(rdata_o, 16'h5080)
        @(posedge clk_sys_i);
        #2;
        `CHECK(conv_o, 1'b0)
        complete_run();
    end
endmodule // tb_top
